// file: mpr_host_pkg.sv
// constants and types for the special-register access controller
package mpr_host_pkg;

	// ----------------------------------------------------------------
	// software port
	// ----------------------------------------------------------------
	localparam int          ADDR_W     = 8;
	localparam int          DATA_W     = 32;
	localparam logic [7:0]  OFF_CMD    = 8'h00;
	localparam logic [7:0]  OFF_PAGE   = 8'h04;
	localparam logic [7:0]  OFF_LOC    = 8'h08;
	localparam logic [7:0]  OFF_WDATA  = 8'h0c;
	localparam logic [7:0]  OFF_RDATA  = 8'h10;
	localparam logic [7:0]  OFF_STATUS = 8'h14;
	localparam logic [2:0]  OP_ENTER   = 3'h1;
	localparam logic [2:0]  OP_EXIT    = 3'h2;
	localparam logic [2:0]  OP_READ    = 3'h3;
	localparam logic [2:0]  OP_WRITE   = 3'h4;
	localparam logic [2:0]  OP_REFRESH = 3'h5;
	localparam int          ST_BUSY    = 0;
	localparam int          ST_ON      = 1;
	localparam int          ST_ERR     = 2;

	// ----------------------------------------------------------------
	// memory command pins {act_n, ras_n, cas_n, we_n}
	// ----------------------------------------------------------------
	localparam logic [3:0]  PIN_DES    = 4'hf;
	localparam logic [3:0]  PIN_MRS    = 4'h8;
	localparam logic [3:0]  PIN_REF    = 4'h9;
	localparam logic [3:0]  PIN_PRE    = 4'ha;
	localparam logic [3:0]  PIN_WR     = 4'hc;
	localparam logic [3:0]  PIN_RD     = 4'hd;
	localparam logic        MR3_BG     = 1'h0;
	localparam logic [1:0]  MR3_BA     = 2'h3;
	localparam int          MR3_EN_BIT = 2;
	localparam int          PRE_ALL    = 10;
	localparam logic [2:0]  BURST_LOW  = 3'h0;
	localparam logic [1:0]  PAGE_TRAIN = 2'h0;
	localparam int          MEM_A_W    = 18;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int T_RP_NS       = 15;
	localparam int T_RFC_NS      = 260;
	localparam int T_RP_CYC      =
		(T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_RFC_CYC     =
		(T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_MOD_NCK     = 24;
	localparam int RD_LAT_NCK    = 16;
	localparam int WR_GAP_NCK    = 8;
	localparam int TMR_W         = 8;
	localparam int UI_PER_BURST  = 8;

	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_PRE  = 4'h1,
		S_PREW = 4'h2,
		S_MRS  = 4'h3,
		S_WAIT = 4'h4,
		S_RD   = 4'h5,
		S_RDL  = 4'h6,
		S_RDC  = 4'h7,
		S_WR   = 4'h8,
		S_REF  = 4'h9
	} state_t;

endpackage

// file: mpr_ctl_if.sv
// link between the controller and its timer and burst capture
`timescale 1ns/10ps
interface mpr_ctl_if #(
	parameter int TMR_W = 8
);
	logic             load;
	logic [TMR_W-1:0] count;
	logic             done;
	logic             capStart;
	logic             capBit;
	logic             capDone;
	logic [7:0]       capByte;

	modport main (output load, count, capStart, capBit,
		input done, capDone, capByte);
	modport tmr  (input load, count, output done);
	modport cap  (input capStart, capBit, output capDone, capByte);
endinterface

// file: mpr_wait_timer.sv
// down counter that times the gaps after each memory command
`timescale 1ns/10ps
module mpr_wait_timer (
	input wire logic clk,
	input wire logic rstn,
	mpr_ctl_if.tmr   bus
);
	localparam int TMR_W = mpr_host_pkg::TMR_W;

	logic [TMR_W-1:0] cnt_ff;
	logic [TMR_W-1:0] nxt_cnt;

	always_comb begin
		nxt_cnt = cnt_ff;
		if (bus.load) begin
			nxt_cnt = bus.count;
		end else if (cnt_ff != '0) begin
			nxt_cnt = cnt_ff - TMR_W'(1);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	assign bus.done = (cnt_ff == '0);
endmodule // mpr_wait_timer

// file: mpr_burst_capture.sv
// collects one serial burst from the data lane, first bit on top
`timescale 1ns/10ps
module mpr_burst_capture (
	input wire logic clk,
	input wire logic rstn,
	mpr_ctl_if.cap   bus
);
	localparam int UI_N = mpr_host_pkg::UI_PER_BURST;

	logic [3:0] cnt_ff;
	logic [3:0] nxt_cnt;
	logic [7:0] byte_ff;
	logic [7:0] nxt_byte;
	logic       done_ff;
	logic       nxt_done;

	// first unit interval ends in bit 7
	always_comb begin
		nxt_cnt  = cnt_ff;
		nxt_byte = byte_ff;
		nxt_done = 1'b0;
		if (bus.capStart) begin
			nxt_cnt = 4'(UI_N);
		end else if (cnt_ff != 4'h0) begin
			nxt_byte = {byte_ff[6:0], bus.capBit};
			nxt_cnt  = cnt_ff - 4'h1;
			nxt_done = (cnt_ff == 4'h1);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_ff  <= 4'h0;
			byte_ff <= 8'h00;
			done_ff <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			byte_ff <= nxt_byte;
			done_ff <= nxt_done;
		end
	end

	assign bus.capDone = done_ff;
	assign bus.capByte = byte_ff;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	msb_first_a: assert property (@(posedge clk) disable iff (!rstn)
		done_ff |-> byte_ff[7] == $past(bus.capBit, 8)
			&& byte_ff[0] == $past(bus.capBit))
		else $error("burst bit order wrong");
	burst_done_c: cover property (@(posedge clk) disable iff (!rstn)
		done_ff);
endmodule // mpr_burst_capture

// file: mpr_host.sv
// controller that drives special-register access on a memory device
//
// Overview of operation
// - mode entry, exit and page choice go only by mode register set.
// - data bus inversion stays off for every special-register read.
// - all banks precharged and precharge time met before that command.
// - in the mode only set, read, write, deselect, refresh, reset allowed.
// - bank address bits of a read pick the register in the page.
// - no power down and no self refresh entry while the mode is on.
// - normal refresh only; no command until refresh time has passed.
// - finish any register read or write before a refresh command.
// - reset is taken in the mode; full initialization must follow.
// - reads use fixed burst eight, low address 000; no on-the-fly.
// - register bit 7 comes in the first interval, bit 0 in the last.
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/10ps
module mpr_host #(
	parameter int RD_LAT = mpr_host_pkg::RD_LAT_NCK
)(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [31:0] regRdata,
	output logic             memResetN,
	output logic             memCke,
	output logic             memCsN,
	output logic             memActN,
	output logic             memRasN,
	output logic             memCasN,
	output logic             memWeN,
	output logic             memBg,
	output logic      [1:0]  memBa,
	output logic      [17:0] memAddr,
	output logic             memDbiN,
	input  wire logic        dqLane0
);
	localparam int TMR_W = mpr_host_pkg::TMR_W;
	localparam int AW    = mpr_host_pkg::MEM_A_W;

	mpr_ctl_if #(.TMR_W(TMR_W)) ctl ();

	mpr_wait_timer u_tmr (
		.clk  (clk),
		.rstn (rstn),
		.bus  (ctl.tmr)
	);

	mpr_burst_capture u_cap (
		.clk  (clk),
		.rstn (rstn),
		.bus  (ctl.cap)
	);

	assign ctl.capBit = dqLane0;

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	logic [1:0]  page_ff,   nxt_page;
	logic [1:0]  loc_ff,    nxt_loc;
	logic [7:0]  wdata_ff,  nxt_wdata;
	logic [31:0] rdBus_ff,  nxt_rdBus;
	logic        opReq;
	logic        errClr;
	logic [7:0]  rdata_ff,  nxt_rdata;
	logic        err_ff,    nxt_err;
	logic        mprOn_ff,  nxt_on;
	logic [1:0]  actPage_ff, nxt_actPage;
	mpr_host_pkg::state_t state_ff, nxt_state;

	always_comb begin
		nxt_page  = page_ff;
		nxt_loc   = loc_ff;
		nxt_wdata = wdata_ff;
		nxt_rdBus = '0;
		opReq     = 1'b0;
		errClr    = 1'b0;
		if (regWr) begin
			case (regAddr)
				mpr_host_pkg::OFF_CMD:    opReq     = 1'b1;
				mpr_host_pkg::OFF_PAGE:   nxt_page  = regWdata[1:0];
				mpr_host_pkg::OFF_LOC:    nxt_loc   = regWdata[1:0];
				mpr_host_pkg::OFF_WDATA:  nxt_wdata = regWdata[7:0];
				mpr_host_pkg::OFF_STATUS:
					errClr = regWdata[mpr_host_pkg::ST_ERR];
				default:                  opReq     = 1'b0;
			endcase
		end
		if (regRd) begin
			case (regAddr)
				mpr_host_pkg::OFF_PAGE:  nxt_rdBus = {30'h0, page_ff};
				mpr_host_pkg::OFF_LOC:   nxt_rdBus = {30'h0, loc_ff};
				mpr_host_pkg::OFF_WDATA: nxt_rdBus = {24'h0, wdata_ff};
				mpr_host_pkg::OFF_RDATA: nxt_rdBus = {24'h0, rdata_ff};
				mpr_host_pkg::OFF_STATUS: begin
					nxt_rdBus[mpr_host_pkg::ST_BUSY] =
						(state_ff != mpr_host_pkg::S_IDLE);
					nxt_rdBus[mpr_host_pkg::ST_ON]  = mprOn_ff;
					nxt_rdBus[mpr_host_pkg::ST_ERR] = err_ff;
				end
				default: nxt_rdBus = '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			page_ff  <= 2'h0;
			loc_ff   <= 2'h0;
			wdata_ff <= 8'h00;
			rdBus_ff <= 32'h0;
		end else begin
			page_ff  <= nxt_page;
			loc_ff   <= nxt_loc;
			wdata_ff <= nxt_wdata;
			rdBus_ff <= nxt_rdBus;
		end
	end

	assign regRdata = rdBus_ff;

	// ----------------------------------------------------------------
	// command sequencer
	// ----------------------------------------------------------------
	logic          mrsEn_ff,  nxt_mrsEn;
	logic          csN_ff,    nxt_csN;
	logic [3:0]    pins_ff,   nxt_pins;
	logic          bg_ff,     nxt_bg;
	logic [1:0]    ba_ff,     nxt_ba;
	logic [AW-1:0] addr_ff,   nxt_addr;
	logic          rstOut_ff;
	logic          cke_ff;
	logic          dbiN_ff;
	logic          refuse;

	always_comb begin
		nxt_state = state_ff;
		nxt_on    = mprOn_ff;
		nxt_actPage = actPage_ff;
		nxt_mrsEn = mrsEn_ff;
		nxt_rdata = rdata_ff;
		nxt_csN   = 1'b1;
		nxt_pins  = mpr_host_pkg::PIN_DES;
		nxt_bg    = 1'b0;
		nxt_ba    = 2'h0;
		nxt_addr  = '0;
		ctl.load     = 1'b0;
		ctl.count    = '0;
		ctl.capStart = 1'b0;
		refuse       = opReq && (state_ff != mpr_host_pkg::S_IDLE);
		case (state_ff)
			mpr_host_pkg::S_IDLE: begin
				if (opReq) begin
					nxt_mrsEn = (regWdata[2:0] == mpr_host_pkg::OP_ENTER);
					case (regWdata[2:0])
						// precharge only when entering from normal
						mpr_host_pkg::OP_ENTER: nxt_state = mprOn_ff ?
							mpr_host_pkg::S_MRS : mpr_host_pkg::S_PRE;
						mpr_host_pkg::OP_EXIT:
							if (mprOn_ff) nxt_state = mpr_host_pkg::S_MRS;
							else refuse = 1'b1;
						mpr_host_pkg::OP_READ:
							if (mprOn_ff) nxt_state = mpr_host_pkg::S_RD;
							else refuse = 1'b1;
						// writes go to page 0 only
						mpr_host_pkg::OP_WRITE:
							if (mprOn_ff &&
								actPage_ff == mpr_host_pkg::PAGE_TRAIN)
								nxt_state = mpr_host_pkg::S_WR;
							else refuse = 1'b1;
						mpr_host_pkg::OP_REFRESH:
							if (mprOn_ff) nxt_state = mpr_host_pkg::S_REF;
							else refuse = 1'b1;
						default: refuse = 1'b1;
					endcase
				end
			end
			mpr_host_pkg::S_PRE: begin
				// precharge all banks, wait precharge time
				nxt_csN           = 1'b0;
				nxt_pins          = mpr_host_pkg::PIN_PRE;
				nxt_addr[mpr_host_pkg::PRE_ALL] = 1'b1;
				ctl.load          = 1'b1;
				ctl.count         = TMR_W'(mpr_host_pkg::T_RP_CYC);
				nxt_state         = mpr_host_pkg::S_PREW;
			end
			mpr_host_pkg::S_PREW:
				if (ctl.done) nxt_state = mpr_host_pkg::S_MRS;
			mpr_host_pkg::S_MRS: begin
				// page and enable only through mode register 3
				nxt_csN     = 1'b0;
				nxt_pins    = mpr_host_pkg::PIN_MRS;
				nxt_bg      = mpr_host_pkg::MR3_BG;
				nxt_ba      = mpr_host_pkg::MR3_BA;
				nxt_addr[1:0] = page_ff;
				nxt_addr[mpr_host_pkg::MR3_EN_BIT] = mrsEn_ff;
				// cleared enable returns to array access
				nxt_on      = mrsEn_ff;
				nxt_actPage = page_ff;
				ctl.load    = 1'b1;
				ctl.count   = TMR_W'(mpr_host_pkg::T_MOD_NCK);
				nxt_state   = mpr_host_pkg::S_WAIT;
			end
			mpr_host_pkg::S_WAIT:
				if (ctl.done) nxt_state = mpr_host_pkg::S_IDLE;
			mpr_host_pkg::S_RD: begin
				nxt_csN     = 1'b0;
				nxt_pins    = mpr_host_pkg::PIN_RD;
				nxt_ba      = loc_ff;
				nxt_addr[2:0] = mpr_host_pkg::BURST_LOW;
				ctl.load    = 1'b1;
				ctl.count   = TMR_W'(RD_LAT - 1);
				nxt_state   = mpr_host_pkg::S_RDL;
			end
			mpr_host_pkg::S_RDL:
				if (ctl.done) begin
					ctl.capStart = 1'b1;
					nxt_state    = mpr_host_pkg::S_RDC;
				end
			mpr_host_pkg::S_RDC:
				if (ctl.capDone) begin
					nxt_rdata = ctl.capByte;
					nxt_state = mpr_host_pkg::S_IDLE;
				end
			mpr_host_pkg::S_WR: begin
				nxt_csN       = 1'b0;
				nxt_pins      = mpr_host_pkg::PIN_WR;
				nxt_ba        = loc_ff;
				nxt_addr[7:0] = wdata_ff;
				ctl.load      = 1'b1;
				ctl.count     = TMR_W'(mpr_host_pkg::WR_GAP_NCK);
				nxt_state     = mpr_host_pkg::S_WAIT;
			end
			mpr_host_pkg::S_REF: begin
				// hold off all commands for refresh time
				nxt_csN   = 1'b0;
				nxt_pins  = mpr_host_pkg::PIN_REF;
				ctl.load  = 1'b1;
				ctl.count = TMR_W'(mpr_host_pkg::T_RFC_CYC);
				nxt_state = mpr_host_pkg::S_WAIT;
			end
			default: nxt_state = mpr_host_pkg::S_IDLE;
		endcase
		// set wins over a clear in the same cycle
		nxt_err = (err_ff && !errClr) || refuse;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			// reset leaves the mode; init must be redone
			state_ff  <= mpr_host_pkg::S_IDLE;
			mprOn_ff  <= 1'b0;
			actPage_ff <= 2'h0;
			mrsEn_ff  <= 1'b0;
			rdata_ff  <= 8'h00;
			err_ff    <= 1'b0;
			csN_ff    <= 1'b1;
			pins_ff   <= mpr_host_pkg::PIN_DES;
			bg_ff     <= 1'b0;
			ba_ff     <= 2'h0;
			addr_ff   <= '0;
			rstOut_ff <= 1'b0;
			cke_ff    <= 1'b0;
			dbiN_ff   <= 1'b1;
		end else begin
			state_ff  <= nxt_state;
			mprOn_ff  <= nxt_on;
			actPage_ff <= nxt_actPage;
			mrsEn_ff  <= nxt_mrsEn;
			rdata_ff  <= nxt_rdata;
			err_ff    <= nxt_err;
			csN_ff    <= nxt_csN;
			pins_ff   <= nxt_pins;
			bg_ff     <= nxt_bg;
			ba_ff     <= nxt_ba;
			addr_ff   <= nxt_addr;
			rstOut_ff <= 1'b1;
			cke_ff    <= 1'b1;
			dbiN_ff   <= 1'b1;
		end
	end

	assign memResetN = rstOut_ff;
	assign memCke    = cke_ff;
	assign memCsN    = csN_ff;
	assign {memActN, memRasN, memCasN, memWeN} = pins_ff;
	assign memBg     = bg_ff;
	assign memBa     = ba_ff;
	assign memAddr   = addr_ff;
	assign memDbiN   = dbiN_ff;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic       isCmd;
	logic       isRdWr;
	logic [7:0] preAge_ff;
	logic [7:0] cmdAge_ff;
	logic       lastRef_ff;

	assign isCmd  = !csN_ff;
	assign isRdWr = isCmd && (pins_ff == mpr_host_pkg::PIN_RD
		|| pins_ff == mpr_host_pkg::PIN_WR);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			preAge_ff  <= 8'h00;
			cmdAge_ff  <= 8'h00;
			lastRef_ff <= 1'b0;
		end else begin
			preAge_ff <= (isCmd && pins_ff == mpr_host_pkg::PIN_PRE) ?
				8'h00 : (preAge_ff == 8'hff ? 8'hff : preAge_ff + 8'h01);
			cmdAge_ff <= isCmd ? 8'h00 :
				(cmdAge_ff == 8'hff ? 8'hff : cmdAge_ff + 8'h01);
			if (isCmd) lastRef_ff <= (pins_ff == mpr_host_pkg::PIN_REF);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	pre_before_mrs_a: assert property (
		isCmd && pins_ff == mpr_host_pkg::PIN_MRS && addr_ff[2]
			&& !$past(mprOn_ff) |-> preAge_ff >= 8'(mpr_host_pkg::T_RP_CYC))
		else $error("mode entry without precharge time");
	refresh_gap_a: assert property (
		isCmd && lastRef_ff |->
			cmdAge_ff >= 8'(mpr_host_pkg::T_RFC_CYC))
		else $error("command inside refresh time");
	allowed_cmds_a: assert property (
		isCmd && mprOn_ff |-> pins_ff != mpr_host_pkg::PIN_PRE)
		else $error("forbidden command in register mode");
	cke_kept_a: assert property (
		mprOn_ff |-> memCke && $past(memCke))
		else $error("clock enable dropped in register mode");
	burst_addr_a: assert property (
		isCmd && pins_ff == mpr_host_pkg::PIN_RD |->
			addr_ff[2:0] == mpr_host_pkg::BURST_LOW && !dbiN_ff == 1'b0)
		else $error("read with bad burst bits or inversion");
	page0_write_a: assert property (
		isCmd && pins_ff == mpr_host_pkg::PIN_WR |->
			mprOn_ff && actPage_ff == mpr_host_pkg::PAGE_TRAIN)
		else $error("register write outside page 0");
	ref_after_io_a: assert property (
		isCmd && pins_ff == mpr_host_pkg::PIN_REF |->
			!$past(isRdWr) && !$past(isRdWr, 2))
		else $error("refresh right after register access");
	exit_clears_a: assert property (
		isCmd && pins_ff == mpr_host_pkg::PIN_MRS && !addr_ff[2] |->
			!mprOn_ff ##1 !mprOn_ff)
		else $error("mode still on after exit");
	read_flow_c: cover property (
		isCmd && pins_ff == mpr_host_pkg::PIN_RD ##[1:40] ctl.capDone);
	write_flow_c: cover property (isRdWr && !pins_ff[0]);
	refresh_flow_c: cover property (
		isCmd && pins_ff == mpr_host_pkg::PIN_REF);
endmodule // mpr_host

// file: mpr_dev_model.sv
// behavioural memory device serving special-register access
`timescale 1ns/10ps
module mpr_dev_model #(
	parameter int          RD_LAT = 16,
	parameter logic [31:0] P1_LOG = 32'h0000_0000,
	parameter logic [31:0] P3_RSV = 32'h0000_0000
)(
	input  wire logic        clk,
	input  wire logic        memResetN,
	input  wire logic        memCke,
	input  wire logic        memCsN,
	input  wire logic [3:0]  memCmd,
	input  wire logic        memBg,
	input  wire logic [1:0]  memBa,
	input  wire logic [17:0] memAddr,
	input  wire logic        memDbiN,
	output logic             dqLane0,
	output int               violCount
);
	// array data when the mode is off
	localparam logic [7:0] ARRAY_BYTE = 8'hc3;

	logic [7:0] pg0 [4];
	logic       modeOn = 1'b0;
	logic [1:0] page = 2'h0;
	logic [7:0] rdByte = 8'h00;
	logic       bad;
	int         n;
	int         cyc = 0;
	int         rdAt = -100;
	int         preAge = 1000;
	int         refAge = 1000;

	initial dqLane0 = 1'b0;
	initial violCount = 0;

	function automatic logic [7:0] pick(input logic [1:0] loc);
		case (page)
			2'h0: pick = pg0[loc];
			2'h1: pick = P1_LOG[8*loc +: 8];
			2'h2: pick = (loc == 2'h3) ? {5'h0, modeOn, page} : 8'h00;
			default: pick = P3_RSV[8*loc +: 8];
		endcase
	endfunction

	always @(posedge clk) begin
		n = cyc - rdAt - (RD_LAT - 1);
		bad = 1'b0;
		cyc <= cyc + 1;
		preAge <= preAge + 1;
		refAge <= refAge + 1;
		if (n >= 0 && n < 8)
			dqLane0 <= rdByte[7 - n];
		else
			dqLane0 <= !dqLane0;
		if (!memResetN) begin
			pg0 <= '{8'h55, 8'h33, 8'h0f, 8'h00};
			modeOn <= 1'b0;
			page <= 2'h0;
		end else begin
			// no power down in the mode
			bad = modeOn && !memCke;
			if (!memCsN)
				bad |= refAge < mpr_host_pkg::T_RFC_CYC;
			if (!memCsN) begin
				case (memCmd)
					mpr_host_pkg::PIN_PRE: begin
						bad |= modeOn;
						preAge <= 0;
					end
					mpr_host_pkg::PIN_MRS: begin
						bad |= preAge < mpr_host_pkg::T_RP_CYC;
						if (memBg == 1'b0 && memBa == 2'h3) begin
							modeOn <= memAddr[2];
							page <= memAddr[1:0];
						end
					end
					mpr_host_pkg::PIN_REF: begin
						bad |= n < 8;
						refAge <= 0;
					end
					mpr_host_pkg::PIN_RD: begin
						bad |= !memDbiN || memAddr[1:0] != 2'h0;
						rdAt <= cyc;
						rdByte <= modeOn ? pick(memBa) : ARRAY_BYTE;
					end
					mpr_host_pkg::PIN_WR: begin
						if (modeOn && page == 2'h0)
							pg0[memBa] <= memAddr[7:0];
					end
					default: bad = 1'b1;
				endcase
			end
		end
		if (bad)
			violCount <= violCount + 1;
	end
endmodule // mpr_dev_model

// file: test_multipurpose_register_access.sv
// self-checking bench for the special-register access controller
`timescale 1ns/10ps
module test_multipurpose_register_access;
	typedef struct {
		logic [2:0] op;
		logic [1:0] pg;
		logic [1:0] loc;
		logic [7:0] wd;
		logic [2:0] st;
		logic [7:0] rd;
	} row_t;
	localparam int          LAT = 4;
	localparam logic [31:0] P1  = 32'hc4a2_9e17;
	localparam logic [31:0] P3  = 32'h6b0d_f3e8;
	localparam logic [2:0]  EN  = mpr_host_pkg::OP_ENTER;
	localparam logic [2:0]  EX  = mpr_host_pkg::OP_EXIT;
	localparam logic [2:0]  RD  = mpr_host_pkg::OP_READ;
	localparam logic [2:0]  WR  = mpr_host_pkg::OP_WRITE;
	localparam logic [2:0]  RF  = mpr_host_pkg::OP_REFRESH;
	localparam logic [7:0]  STA = mpr_host_pkg::OFF_STATUS;

	logic        clk       = 1'b0;
	logic        rstn      = 1'b0;
	logic [7:0]  regAddr   = 8'h00;
	logic [31:0] regWdata  = 32'h0;
	logic        regWr     = 1'b0;
	logic        regRd     = 1'b0;
	logic [31:0] regRdata;
	logic        memResetN, memCke, memCsN, memActN, memRasN;
	logic        memCasN, memWeN, memBg, memDbiN, dqLane0;
	logic [1:0]  memBa;
	logic [17:0] memAddr;
	int          violCount;
	int          nMismatch  = 0;
	int          checkCount = 0;

	row_t rows [24] = '{
		'{EN, 2'h0, 2'h0, 8'h00, 3'h2, 8'h00},
		'{RD, 2'h0, 2'h0, 8'h00, 3'h2, 8'h55},
		'{RD, 2'h0, 2'h1, 8'h00, 3'h2, 8'h33},
		'{RD, 2'h0, 2'h2, 8'h00, 3'h2, 8'h0f},
		'{RD, 2'h0, 2'h3, 8'h00, 3'h2, 8'h00},
		'{WR, 2'h0, 2'h2, 8'ha5, 3'h2, 8'h00},
		'{RD, 2'h0, 2'h2, 8'h00, 3'h2, 8'ha5},
		'{EN, 2'h1, 2'h0, 8'h00, 3'h2, 8'h00},
		'{WR, 2'h1, 2'h0, 8'h5a, 3'h6, 8'h00},
		'{WR, 2'h0, 2'h0, 8'h5a, 3'h6, 8'h00},
		'{RD, 2'h1, 2'h0, 8'h00, 3'h2, P1[7:0]},
		'{RD, 2'h1, 2'h3, 8'h00, 3'h2, P1[31:24]},
		'{EN, 2'h2, 2'h0, 8'h00, 3'h2, 8'h00},
		'{RD, 2'h2, 2'h3, 8'h00, 3'h2, 8'h06},
		'{EN, 2'h3, 2'h0, 8'h00, 3'h2, 8'h00},
		'{RD, 2'h3, 2'h1, 8'h00, 3'h2, P3[15:8]},
		'{EN, 2'h0, 2'h0, 8'h00, 3'h2, 8'h00},
		'{RD, 2'h0, 2'h2, 8'h00, 3'h2, 8'ha5},
		'{RF, 2'h0, 2'h0, 8'h00, 3'h2, 8'h00},
		'{RD, 2'h0, 2'h0, 8'h00, 3'h2, 8'h55},
		'{EX, 2'h0, 2'h0, 8'h00, 3'h0, 8'h00},
		'{RD, 2'h0, 2'h0, 8'h00, 3'h4, 8'h00},
		'{WR, 2'h0, 2'h0, 8'h00, 3'h4, 8'h00},
		'{RF, 2'h0, 2'h0, 8'h00, 3'h4, 8'h00}
	};

	mpr_host #(.RD_LAT(LAT)) uut (.clk, .rstn, .regAddr, .regWdata,
		.regWr, .regRd, .regRdata, .memResetN, .memCke, .memCsN,
		.memActN, .memRasN, .memCasN, .memWeN, .memBg, .memBa,
		.memAddr, .memDbiN, .dqLane0);

	mpr_dev_model #(.RD_LAT(LAT), .P1_LOG(P1), .P3_RSV(P3)) dev (.clk,
		.memResetN, .memCke, .memCsN,
		.memCmd({memActN, memRasN, memCasN, memWeN}), .memBg, .memBa,
		.memAddr, .memDbiN, .dqLane0, .violCount);

	always #2 clk = ~clk;

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			nMismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr  <= a;
		regWdata <= d;
		regWr    <= 1'b1;
		@(posedge clk);
		regWr    <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge clk);
		regRd   <= 1'b0;
		#1 d = regRdata;
	endtask

	task automatic waitIdle();
		logic [31:0] s;
		for (int i = 0; i < 300; i++) begin
			rd(STA, s);
			if (s[mpr_host_pkg::ST_BUSY] === 1'b0)
				return;
		end
		chk(s, 32'h0);
	endtask

	task automatic runRow(input row_t r);
		logic [31:0] s;
		wr(mpr_host_pkg::OFF_PAGE, {30'h0, r.pg});
		wr(mpr_host_pkg::OFF_LOC, {30'h0, r.loc});
		wr(mpr_host_pkg::OFF_WDATA, {24'h0, r.wd});
		wr(mpr_host_pkg::OFF_CMD, {29'h0, r.op});
		waitIdle();
		rd(STA, s);
		chk({29'h0, s[2:0]}, {29'h0, r.st});
		wr(STA, 32'h4);
		if (r.op == RD && !r.st[2]) begin
			rd(mpr_host_pkg::OFF_RDATA, s);
			chk(s, {24'h0, r.rd});
		end
	endtask

	task automatic holdReset();
		@(posedge clk);
		rstn <= 1'b0;
		repeat (20) @(posedge clk);
		chk({28'h0, memResetN, memCke, memCsN, memDbiN}, 32'h3);
		rstn <= 1'b1;
		@(posedge clk);
		#1 chk({28'h0, memResetN, memCke, memCsN, memDbiN}, 32'hf);
	endtask

	task automatic endOfTest();
		$display("checks %0d mismatches %0d", checkCount, nMismatch);
		if (nMismatch == 0 && checkCount > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] s;
		holdReset();
		foreach (rows[i])
			runRow(rows[i]);
		holdReset();
		runRow(rows[0]);
		runRow(rows[3]);
		wr(mpr_host_pkg::OFF_CMD, {29'h0, RD});
		wr(mpr_host_pkg::OFF_CMD, {29'h0, RD});
		waitIdle();
		rd(STA, s);
		chk({29'h0, s[2:0]}, 32'h6);
		wr(STA, 32'h4);
		rd(8'h3c, s);
		chk(s, 32'h0);
		rd(mpr_host_pkg::OFF_LOC, s);
		chk(s, 32'h2);
		@(posedge clk);
		#1 chk(regRdata, 32'h0);
		chk(violCount, 32'h0);
		chk({31'h0, memDbiN}, 32'h1);
		endOfTest();
	end

	initial begin
		#100000;
		nMismatch++;
		endOfTest();
	end
endmodule // test_multipurpose_register_access
